// ---- src/pmc_cfg.svh ----
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// register byte offsets
`define PMC_OFS_MODE 12'h000
`define PMC_OFS_CALL 12'h004
`define PMC_OFS_FAULT 12'h008
`define PMC_OFS_WDCTL 12'h00C
`define PMC_OFS_WDCNT 12'h010
`define PMC_OFS_USRWIN 12'h014
`define PMC_OFS_CFG 12'h018
// call register fields
`define PMC_CALL_KIND_POS 7
`define PMC_CALL_RET_POS 8
// watchdog control fields
`define PMC_WD_EN_POS 0
`define PMC_WD_RST_VAL 32'h0000_0000
// post-delivery function enables after reset
`define PMC_FUNC_RST_VAL 8'hFF
// memory sizes in bytes
`define PMC_ROM_TEST_BYTES 32'h0002_0000
`define PMC_ROM_APP_SMALL 32'h0004_B000
`define PMC_ROM_APP_LARGE 32'h0006_0000
`define PMC_EE_MFG_BYTES 32'h0000_0200
`define PMC_EE_FW_BYTES 32'h0000_0300
`define PMC_RAM_FW_BYTES 32'h0000_0380
// vector counts and ROM vector bases
`define PMC_NUM_FWVEC 8
`define PMC_NUM_SYSVEC 32
`define PMC_VEC_EXC_BASE 32'h0000_0000
`define PMC_VEC_IRQ_BASE 32'h0000_0040
`define PMC_VEC_FW_BASE 32'h0000_0100
`define PMC_VEC_SYS_BASE 32'h0000_0200
`endif

// ---- src/pmc_pkg.sv ----
`default_nettype none
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_BOOT, PMC_TEST, PMC_FIRM, PMC_SYS, PMC_USER
  } pmc_mode_t;
  typedef enum logic [1:0] {
    PMC_MEM_ROM, PMC_MEM_EE, PMC_MEM_RAM, PMC_MEM_NONE
  } pmc_mem_t;
endpackage : pmc_pkg
`default_nettype wire

// ---- src/pmc_privilege_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
// Contract
// R1 - five modes, exactly one active
// R2 - super-system is boot, test or firmware
// R3 - software cannot enter super-system sub-modes
// R4 - one program per super-system sub-mode
// R5 - test enabled: reset ends in test
// R6 - test disabled: reset ends in system
// R7 - system unrestricted, user limited by system; the code confines system to the application regions (appHit)
// R8 - exceptions and event interrupts supported
// R9 - each event jumps to fixed vector
// R10 - eight firmware, 32 system vectors, explicit
// R11 - firmware vector enters firmware sub-mode
// R12 - system call vector enters system mode
// R13 - watchdog idle until software enables it
// R14 - each memory split into two parts
// R15 - ROM: 128k test, 300/384k application
// R16 - EEPROM: 512 manufacturer, 768 firmware reserved
// R17 - RAM: 896 firmware, rest application
// R18 - health option lets boot run tests
// R19 - unlocked post-delivery config toggles functions
// R20 - hardware reached only through registers
// R21 - test unrestricted, boot/firmware own regions
// R22 - user window written from system only
// R23 - violating access blocked, raises exception
// R24 - return restores mode before call
module pmc_privilege_ctrl
  import pmc_pkg::*;
#(
  parameter int EXC_NUM = 8,
  parameter int IRQ_NUM = 8,
  parameter int RAM_BYTES = 8320,
  parameter int EE_BYTES = 81920
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // straps and options
  input wire logic testEnable,
  input wire logic romLarge,
  input wire logic healthOption,
  input wire logic cfgOption,
  input wire logic healthReq,
  // cpu events
  input wire logic [EXC_NUM-1:0] excReq,
  input wire logic [IRQ_NUM-1:0] irqReq,
  input wire logic bootDone,
  // cpu memory access check
  input wire logic memValid,
  input wire logic [1:0] memKind,
  input wire logic [31:0] memAddr,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // mode and vector outputs
  output logic [2:0] cpuMode,
  output logic vecJump,
  output logic [31:0] vecAddr,
  output logic memBlock,
  output logic healthRun,
  output logic [7:0] hwFuncEn,
  output logic wdReset
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  pmc_mode_t mode;
  pmc_mode_t savedMode;
  logic inCall;
  logic started;
  logic [31:0] wdCtl;
  logic [31:0] wdCnt;
  logic [31:0] usrWin;
  logic [7:0] funcEn;
  logic cfgLock;
  logic [31:0] faultAddr;
  logic faultSticky;
  logic dpWrite;
  logic [11:0] dpAddr;

  // first set bit index, shared by exception and irq dispatch
  function automatic logic [4:0] pmc_first(input logic [31:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : pmc_first

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire logic addrPhase = hsel && htrans[1] && hready;
  wire logic busWr = dpWrite;
  // R22 user window only from system
  wire logic wrUsr = busWr && dpAddr == `PMC_OFS_USRWIN && mode == PMC_SYS;
  // R3 software cannot write a super-system mode
  wire logic wrCall = busWr && dpAddr == `PMC_OFS_CALL &&
                      (mode == PMC_SYS || mode == PMC_USER ||
                       mode == PMC_FIRM);
  wire logic wrWd = busWr && dpAddr == `PMC_OFS_WDCTL;
  // R19 post-delivery config while unlocked
  wire logic wrCfg = busWr && dpAddr == `PMC_OFS_CFG && cfgOption &&
                     !cfgLock;
  wire logic callRet = wrCall && hwdata[`PMC_CALL_RET_POS];
  wire logic callFw = wrCall && !callRet && !hwdata[`PMC_CALL_KIND_POS];
  wire logic callSys = wrCall && !callRet && hwdata[`PMC_CALL_KIND_POS];
  // R10 eight firmware vectors, 32 system call vectors
  wire logic [4:0] callIdx = callFw ? {2'b00, hwdata[2:0]} : hwdata[4:0];

  // ---------------------------------------------------------------
  // memory region checks
  // ---------------------------------------------------------------
  // R15 rom split by major configuration
  wire logic [31:0] romApp = romLarge ? `PMC_ROM_APP_LARGE :
                                        `PMC_ROM_APP_SMALL;
  // R14 rom test region sits above application region
  wire logic romTest = memAddr >= romApp &&
                       memAddr < romApp + `PMC_ROM_TEST_BYTES;
  wire logic romAppHit = memAddr < romApp;
  // R16 manufacturer then firmware eeprom at the bottom
  wire logic eeRes = memAddr < `PMC_EE_MFG_BYTES + `PMC_EE_FW_BYTES;
  wire logic eeApp = !eeRes && memAddr < 32'(EE_BYTES);
  // R17 firmware ram at the bottom, rest to application
  wire logic ramRes = memAddr < `PMC_RAM_FW_BYTES;
  wire logic ramApp = !ramRes && memAddr < 32'(RAM_BYTES);
  wire pmc_mem_t kind = pmc_mem_t'(memKind);
  wire logic resHit = (kind == PMC_MEM_ROM && romTest) ||
                      (kind == PMC_MEM_EE && eeRes) ||
                      (kind == PMC_MEM_RAM && ramRes);
  wire logic appHit = (kind == PMC_MEM_ROM && romAppHit) ||
                      (kind == PMC_MEM_EE && eeApp) ||
                      (kind == PMC_MEM_RAM && ramApp);
  // R7 user limited to window granted by system
  wire logic usrOk = appHit && memAddr[31:12] >= {4'h0, usrWin[15:0]} &&
                     memAddr[31:12] <= {4'h0, usrWin[31:16]};
  // R21 test unrestricted, boot and firmware reserved only
  wire logic accOk = mode == PMC_TEST ? 1'b1 :
                     (mode == PMC_BOOT || mode == PMC_FIRM) ? resHit :
                     mode == PMC_SYS ? appHit : usrOk;
  wire logic violation = memValid && !accOk;

  // ---------------------------------------------------------------
  // event dispatch
  // ---------------------------------------------------------------
  wire logic wdExpire = wdCtl[`PMC_WD_EN_POS] && wdCnt == 32'h0000_0001;
  // R23 violation counts as exception zero
  wire logic [31:0] excAll = 32'(excReq) | {31'h0, violation | wdExpire};
  wire logic anyExc = |excAll;
  wire logic anyIrq = |irqReq;
  // R9 fixed rom vector per event, exceptions first
  wire logic [31:0] evtVec = anyExc ?
      `PMC_VEC_EXC_BASE + {25'h0, pmc_first(excAll), 2'b00} :
      `PMC_VEC_IRQ_BASE + {25'h0, pmc_first(32'(irqReq)), 2'b00};
  wire logic [31:0] callVec = callFw ?
      `PMC_VEC_FW_BASE + {25'h0, callIdx, 2'b00} :
      `PMC_VEC_SYS_BASE + {25'h0, callIdx, 2'b00};

  // ---------------------------------------------------------------
  // next mode
  // ---------------------------------------------------------------
  pmc_mode_t next_mode;
  always_comb begin
    next_mode = mode;
    if (!started) begin
      // R4 boot program runs first
      next_mode = PMC_BOOT;
    end else if (mode == PMC_BOOT && bootDone && !healthRun) begin
      // R5 test while enabled
      // R6 system after test disabled
      next_mode = testEnable ? PMC_TEST : PMC_SYS;
    end else if (callFw) begin
      // R11 firmware vector enters firmware
      next_mode = PMC_FIRM;
    end else if (callSys) begin
      // R12 system call enters system
      next_mode = PMC_SYS;
    end else if (callRet && inCall) begin
      // R24 restore caller mode
      next_mode = savedMode;
    end else if (callRet && mode == PMC_SYS) begin
      // R7 system code drops to user with no call open
      // a plain return from system, or a return to a user caller, leads into user
      next_mode = PMC_USER;
    end
  end

  // ---------------------------------------------------------------
  // mode register
  // ---------------------------------------------------------------
  // R1 single encoded mode register
  // R2 super-system held as sub-mode only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode <= PMC_BOOT;
      savedMode <= PMC_SYS;
      inCall <= 1'b0;
      started <= 1'b0;
    end else begin
      started <= 1'b1;
      mode <= next_mode;
      if (callFw || callSys) begin
        savedMode <= mode;
        inCall <= 1'b1;
      end else if (callRet) begin
        inCall <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // health option during boot
  // ---------------------------------------------------------------
  // R18 boot holds for self test when asked
  // dropping healthReq releases the hold; boot then leaves on bootDone
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      healthRun <= 1'b0;
    end else if (mode == PMC_BOOT && healthOption && healthReq) begin
      healthRun <= 1'b1;
    end else if (!healthReq) begin
      healthRun <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // vector jumps and blocking
  // ---------------------------------------------------------------
  // R8 exceptions and interrupts both dispatched
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vecJump <= 1'b0;
      vecAddr <= 32'h0000_0000;
      memBlock <= 1'b0;
    end else begin
      vecJump <= anyExc || anyIrq || callFw || callSys;
      // R23 block the violating access
      memBlock <= violation;
      if (anyExc || anyIrq) begin
        vecAddr <= evtVec;
      end else if (callFw || callSys) begin
        vecAddr <= callVec;
      end
    end
  end

  // ---------------------------------------------------------------
  // fault capture, set wins over clear
  // ---------------------------------------------------------------
  // a bus clear in the same cycle as a violation is lost on purpose
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      faultAddr <= 32'h0000_0000;
      faultSticky <= 1'b0;
    end else if (violation) begin
      faultAddr <= memAddr;
      faultSticky <= 1'b1;
    end else if (busWr && dpAddr == `PMC_OFS_FAULT) begin
      faultSticky <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  // R13 inactive until enabled and loaded
  // expiry fires as the count leaves one; a load of zero never fires,
  // so the dog stays silent until a nonzero count is loaded, before or after enabling
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wdCtl <= `PMC_WD_RST_VAL;
      wdCnt <= 32'h0000_0000;
      wdReset <= 1'b0;
    end else begin
      wdReset <= wdExpire;
      if (wrWd) begin
        wdCtl <= hwdata;
      end
      if (busWr && dpAddr == `PMC_OFS_WDCNT) begin
        wdCnt <= hwdata;
      end else if (wdCtl[`PMC_WD_EN_POS] && wdCnt != 32'h0000_0000) begin
        wdCnt <= wdCnt - 32'h0000_0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // user window and post-delivery config
  // ---------------------------------------------------------------
  // lock is one-way until reset, so a locked setting stays put
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      usrWin <= 32'h0000_0000;
      funcEn <= `PMC_FUNC_RST_VAL;
      cfgLock <= 1'b0;
    end else begin
      if (wrUsr) begin
        usrWin <= hwdata;
      end
      if (wrCfg) begin
        funcEn <= hwdata[7:0];
        cfgLock <= hwdata[31];
      end
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  // R20 all control through mapped registers
  // read mux keyed by the address phase so hrdata can be a flop;
  // a read right behind a write to the same word sees the old value
  wire logic [11:0] rdAddr = haddr[11:0];
  wire logic [31:0] rdMux =
      rdAddr == `PMC_OFS_MODE ? {29'h0, mode} :
      rdAddr == `PMC_OFS_CALL ? {31'h0, inCall} :
      rdAddr == `PMC_OFS_FAULT ? faultAddr :
      rdAddr == `PMC_OFS_WDCTL ? wdCtl :
      rdAddr == `PMC_OFS_WDCNT ? wdCnt :
      rdAddr == `PMC_OFS_USRWIN ? usrWin :
      rdAddr == `PMC_OFS_CFG ? {cfgLock, faultSticky, 22'h0, funcEn} :
      32'h0000_0000;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dpWrite <= 1'b0;
      dpAddr <= 12'h000;
    end else begin
      dpWrite <= addrPhase && hwrite && hsize == 3'b010;
      if (addrPhase) begin
        dpAddr <= haddr[11:0];
      end
    end
  end

  // read data captured at the address phase edge, stands the data phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0000_0000;
    end else if (addrPhase && !hwrite) begin
      hrdata <= rdMux;
    end
  end

  // bus answer and mirrored outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cpuMode <= 3'h0;
      hwFuncEn <= `PMC_FUNC_RST_VAL;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      cpuMode <= next_mode;
      hwFuncEn <= funcEn;
    end
  end

endmodule : pmc_privilege_ctrl
`default_nettype wire

// ---- test/pmc_privilege_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmc_privilege_ctrl_assertions
  import pmc_pkg::*;
#(
  parameter int EXC_NUM = 8,
  parameter int IRQ_NUM = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // straps and events
  input wire logic testEnable,
  input wire logic healthOption,
  input wire logic healthReq,
  input wire logic cfgOption,
  input wire logic bootDone,
  input wire logic memValid,
  input wire logic [EXC_NUM-1:0] excReq,
  input wire logic [IRQ_NUM-1:0] irqReq,
  // observed outputs
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [2:0] cpuMode,
  input wire logic vecJump,
  input wire logic [31:0] vecAddr,
  input wire logic memBlock,
  input wire logic healthRun,
  input wire logic [7:0] hwFuncEn,
  input wire logic wdReset
);
  // --------------------
  // mode and vector checks
  // --------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // boot exit only judged when nothing competes with it
  wire quietBoot;
  assign quietBoot = cpuMode == 3'h0 && bootDone && !healthRun &&
    !(healthOption && healthReq) && !(|excReq) && !(|irqReq) && !memValid;
  a_mode_legal: assert property (cpuMode <= 3'h4)
    else $error("cpu mode out of range");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  a_boot_test: assert property (
    quietBoot && $past(rstn) && testEnable |=> cpuMode == 3'h1)
    else $error("boot did not end in test");
  a_boot_sys: assert property (
    quietBoot && $past(rstn) && !testEnable |=> cpuMode == 3'h3)
    else $error("boot did not end in system");
  a_fw_mode: assert property (
    vecJump && vecAddr[31:5] == 27'h8 |-> cpuMode == 3'h2)
    else $error("firmware vector without firmware mode");
  a_sys_mode: assert property (
    vecJump && vecAddr[31:7] == 25'h4 |-> cpuMode == 3'h3)
    else $error("system vector without system mode");
  a_vec_fixed: assert property (
    vecJump |-> vecAddr < 32'h280 && vecAddr[1:0] == 2'h0)
    else $error("vector outside fixed table");
  a_block_exc: assert property (
    memBlock |-> vecJump && vecAddr == 32'h0)
    else $error("blocked access without exception");
  a_wd_exc: assert property (
    wdReset |-> vecJump && vecAddr == 32'h0)
    else $error("watchdog expiry without exception");
  a_super_gate: assert property (
    cpuMode == 3'h3 || cpuMode == 3'h4 |=> cpuMode != 3'h0 &&
    cpuMode != 3'h1)
    else $error("software reached boot or test mode");
  a_func_hold: assert property (!cfgOption |=> $stable(hwFuncEn))
    else $error("functions changed while option off");
endmodule : pmc_privilege_ctrl_assertions
bind pmc_privilege_ctrl pmc_privilege_ctrl_assertions #(.EXC_NUM(EXC_NUM),
  .IRQ_NUM(IRQ_NUM)) i_pmc_privilege_ctrl_assertions (.clk_sys, .rstn,
  .testEnable, .healthOption, .healthReq, .cfgOption, .bootDone, .memValid,
  .excReq, .irqReq, .hreadyout, .hresp, .cpuMode, .vecJump, .vecAddr,
  .memBlock, .healthRun, .hwFuncEn, .wdReset);
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module tb;
  // --------------------
  // signals and device
  // --------------------
  logic clk_sys, rstn, testEnable, romLarge, healthOption, cfgOption;
  logic healthReq, bootDone, memValid, hsel, hwrite, hreadyout, hresp;
  logic vecJump, memBlock, healthRun, wdReset;
  logic [7:0] excReq, irqReq, hwFuncEn;
  logic [1:0] memKind, htrans;
  logic [2:0] hsize, cpuMode;
  logic [31:0] memAddr, haddr, hwdata, hrdata, vecAddr, rdata;
  int error_cnt, checked;
  // hready fed back from the single slave
  pmc_privilege_ctrl i_pmc_privilege_ctrl (.clk_sys(clk_sys), .rstn(rstn),
    .testEnable(testEnable), .romLarge(romLarge),
    .healthOption(healthOption), .cfgOption(cfgOption),
    .healthReq(healthReq), .excReq(excReq), .irqReq(irqReq),
    .bootDone(bootDone), .memValid(memValid), .memKind(memKind),
    .memAddr(memAddr), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cpuMode(cpuMode), .vecJump(vecJump), .vecAddr(vecAddr),
    .memBlock(memBlock), .healthRun(healthRun), .hwFuncEn(hwFuncEn),
    .wdReset(wdReset));
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // --------------------
  // helpers and scenarios
  // --------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  task timeout_hit;
    error_cnt++;
    $display("MISMATCH t=%0t wait timed out", $time);
    end_of_test;
  endtask : timeout_hit
  // bounded waits, looked at just after each edge has settled
  task automatic wait_hi(ref logic s);
    for (int k = 0; k < 60; k++) begin
      #1;
      if (s === 1'b1) return;
      @(posedge clk_sys);
    end
    timeout_hit;
  endtask : wait_hi
  task wait_mode(input logic [2:0] m);
    for (int k = 0; k < 60; k++) begin
      #1;
      if (cpuMode === m) return;
      @(posedge clk_sys);
    end
    timeout_hit;
  endtask : wait_mode
  task ready;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) return;
    end
    timeout_hit;
  endtask : ready
  // one word transfer; read data taken at the data phase edge
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    ready;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    ready;
    rdata = hrdata;
  endtask : bus
  task probe(input logic [1:0] k, input logic [31:0] a, input logic exp);
    @(posedge clk_sys);
    memValid <= 1'b1;
    memKind <= k;
    memAddr <= a;
    @(posedge clk_sys);
    memValid <= 1'b0;
    #1;
    chk(memBlock, exp);
    if (exp) begin
      bus(1'b0, `PMC_OFS_FAULT, 32'h0);
      chk(rdata, a);
    end
  endtask : probe
  task do_reset;
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask : do_reset
  task t_boot;
    bootDone <= 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    chk(healthRun, 1'b1);
    @(posedge clk_sys);
    healthReq <= 1'b0;
    wait_mode(3'h1);
    chk(cpuMode, 3'h1);
    bus(1'b1, `PMC_OFS_CALL, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk(cpuMode, 3'h1);
    probe(2'h2, 32'h0, 1'b0);
    @(posedge clk_sys);
    testEnable <= 1'b0;
    do_reset;
    chk({24'h0, hwFuncEn}, 32'hFF);
    wait_mode(3'h3);
    chk(cpuMode, 3'h3);
    bus(1'b0, `PMC_OFS_MODE, 32'h0);
    chk(rdata, 32'h3);
  endtask : t_boot
  task t_calls;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `PMC_OFS_CALL, i);
      wait_hi(vecJump);
      chk(vecAddr, `PMC_VEC_FW_BASE + 4 * i);
      chk(cpuMode, 3'h2);
      bus(1'b1, `PMC_OFS_CALL, 32'h100);
      wait_mode(3'h3);
    end
    for (int i = 0; i < 32; i += 31) begin
      bus(1'b1, `PMC_OFS_CALL, 32'h80 + i);
      wait_hi(vecJump);
      chk(vecAddr, `PMC_VEC_SYS_BASE + 4 * i);
    end
    bus(1'b1, `PMC_OFS_CALL, 32'h3);
    wait_mode(3'h2);
    bus(1'b1, `PMC_OFS_CALL, 32'h81);
    wait_mode(3'h3);
    bus(1'b1, `PMC_OFS_CALL, 32'h100);
    wait_mode(3'h2);
    probe(2'h2, 32'h380, 1'b1);
    probe(2'h2, 32'h37C, 1'b0);
    bus(1'b1, `PMC_OFS_CALL, 32'h80);
    wait_mode(3'h3);
  endtask : t_calls
  task t_mem;
    probe(2'h2, 32'h37C, 1'b1);
    probe(2'h2, 32'h380, 1'b0);
    probe(2'h1, 32'h4FC, 1'b1);
    probe(2'h1, 32'h500, 1'b0);
    probe(2'h0, 32'h4AFFC, 1'b0);
    probe(2'h0, 32'h4B000, 1'b1);
    @(posedge clk_sys);
    romLarge <= 1'b1;
    probe(2'h0, 32'h4B000, 1'b0);
    probe(2'h0, 32'h60000, 1'b1);
  endtask : t_mem
  task t_events;
    @(posedge clk_sys);
    excReq <= 8'h08;
    irqReq <= 8'h04;
    @(posedge clk_sys);
    excReq <= 8'h00;
    wait_hi(vecJump);
    chk(vecAddr, `PMC_VEC_EXC_BASE + 32'hC);
    @(posedge clk_sys);
    irqReq <= 8'h00;
    wait_hi(vecJump);
    chk(vecAddr, `PMC_VEC_IRQ_BASE + 32'h8);
  endtask : t_events
  task t_wdog;
    logic seen;
    bus(1'b1, `PMC_OFS_WDCNT, 32'h6);
    seen = 1'b0;
    repeat (20) begin
      @(posedge clk_sys);
      seen = seen | wdReset;
    end
    chk(seen, 1'b0);
    bus(1'b1, `PMC_OFS_WDCTL, 32'h1);
    wait_hi(wdReset);
    chk(vecAddr, `PMC_VEC_EXC_BASE);
    bus(1'b1, `PMC_OFS_WDCTL, 32'h0);
  endtask : t_wdog
  task t_cfg;
    bus(1'b1, `PMC_OFS_FAULT, 32'h0);
    bus(1'b1, `PMC_OFS_CFG, 32'h0F);
    bus(1'b0, `PMC_OFS_CFG, 32'h0);
    chk(rdata, 32'h0000_00FF);
    chk({24'h0, hwFuncEn}, 32'hFF);
    @(posedge clk_sys);
    cfgOption <= 1'b1;
    bus(1'b1, `PMC_OFS_CFG, 32'h8000_000F);
    bus(1'b1, `PMC_OFS_CFG, 32'h33);
    bus(1'b0, `PMC_OFS_CFG, 32'h0);
    chk(rdata, 32'h8000_000F);
    chk({24'h0, hwFuncEn}, 32'h0F);
    bus(1'b1, 32'h20, 32'hDEAD_BEEF);
    bus(1'b0, 32'h20, 32'h0);
    chk(rdata, 32'h0);
  endtask : t_cfg
  // user mode: entered by a plain return from system, window enforced
  task t_user;
    do_reset;
    wait_mode(3'h3);
    bus(1'b1, `PMC_OFS_USRWIN, 32'h0001_0001);
    bus(1'b1, `PMC_OFS_CALL, 32'h100);
    wait_mode(3'h4);
    probe(2'h2, 32'h1000, 1'b0);
    probe(2'h2, 32'h0400, 1'b1);
    bus(1'b1, `PMC_OFS_USRWIN, 32'h0);
    bus(1'b0, `PMC_OFS_USRWIN, 32'h0);
    chk(rdata, 32'h0001_0001);
    bus(1'b1, `PMC_OFS_CALL, 32'h80);
    wait_mode(3'h3);
    bus(1'b1, `PMC_OFS_CALL, 32'h100);
    wait_mode(3'h4);
    bus(1'b0, `PMC_OFS_MODE, 32'h0);
    chk(rdata, 32'h4);
  endtask : t_user
  // main sequence
  initial begin
    {rstn, romLarge, cfgOption, bootDone, memValid, hsel, hwrite} = 7'h0;
    {testEnable, healthOption, healthReq} = 3'h7;
    {excReq, irqReq, memKind, htrans, hsize} = 23'h0;
    {memAddr, haddr, hwdata} = 96'h0;
    error_cnt = 0;
    checked = 0;
    do_reset;
    t_boot;
    t_calls;
    t_mem;
    t_events;
    t_wdog;
    t_cfg;
    t_user;
    end_of_test;
  end
endmodule : tb
`default_nettype wire
